// >>> rtl/utf_framer.sv
// design: payload fifo and udp telegram framer with command acknowledgement
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// payload fifo
// ----------------------------------------------------------------
module utf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             wr;
    logic             rd;

    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    assign cnt_next  = cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_reg   <= '0;
            rd_reg   <= '0;
            cnt_reg  <= '0;
            in_ready <= 1'b0;
        end else begin
            if (wr) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
            end
            if (rd) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
            end
            cnt_reg  <= cnt_next;
            // registered so the source sees a clean ready
            in_ready <= (cnt_next < (AW+1)'(DEPTH));
        end
    end
endmodule // utf_fifo

// Behaviour
// (R1) A telegram is a 30-byte header followed by 0 to 75 two-byte user words.
// (R2) Commands, acknowledgements and measure telegrams all use the same header layout.
// (R3) In measure mode telegrams stream with one idle cycle between them when free running, and one per trigger when triggered.
// (R4) In command mode the framer answers each received command instead of streaming; a command not yet answered is replaced by a newer one.
// (R5) Every multi-byte field leaves low byte first; the 32-bit encoder field sends its high word before its low word.
// (R6) The header opens with two all-ones words, and received telegrams are recognised by them.
// (R7) Fill fields always carry zero.
// (R8) Measure telegrams carry the evaluation code in the command number field.
// (R9) Measure telegrams carry zero in the transaction number field.
// (R10) An acknowledgement carries the answered command number in its transaction number field.
// (R11) The encoder field carries the encoder count when an encoder exists, else zero.
// (R12) The scan number is a full 16-bit unsigned value.
// (R13) The word count field holds only 0, 1, 2, 3 or the large-payload code.
// (R14) The two udp port numbers default to 9008 and 5634 and follow the configuration.
// (R15) The scan number steps by one per measured profile and wraps to zero.
// (R16) The type field always carries the fixed interpretation code.
// (R17) Header fields go out back to back in order with the user words right behind.
module utf_framer
    import utf_pkg::*;
#(
    parameter bit HAS_ENCODER = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire utf_pkg::utf_cfg_s cfg,
    input  wire logic              trigger,
    input  wire logic              profile_done,
    input  wire logic       [31:0] enc_count,
    input  wire logic              pl_valid,
    input  wire logic       [15:0] pl_data,
    output var  logic              pl_ready,
    input  wire logic              rx_valid,
    input  wire logic        [7:0] rx_data,
    input  wire logic              rx_last,
    input  wire logic              tx_ready,
    output var  logic              tx_valid,
    output var  utf_pkg::utf_beat_s tx_beat,
    output var  logic       [15:0] tx_port_a,
    output var  logic       [15:0] tx_port_b
);
    import utf_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    utf_state_e  st_reg;
    logic [7:0]  idx_reg;
    logic [7:0]  last_idx_reg;
    logic        half_reg;
    logic        frame_meas_reg;
    logic [15:0] cmd_lat_reg;
    logic [15:0] trans_lat_reg;
    logic [15:0] stat_lat_reg;
    logic [15:0] cnt_lat_reg;
    logic [15:0] scan_lat_reg;
    logic [15:0] pkt_reg;
    logic [31:0] enc_lat_reg;
    logic [15:0] scan_reg;
    logic        trig_pend_reg;
    logic        ack_pend_reg;
    logic [15:0] ack_cmd_reg;
    logic [15:0] rx_cmd_reg;
    logic [7:0]  rx_idx_reg;
    logic        sof_ok_reg;
    logic        load;
    logic        start_meas;
    logic        start_cmd;
    logic        start;
    logic        hdr_done;
    logic [2:0]  sel;
    logic [15:0] hdr_word;
    logic [7:0]  hdr_byte;
    logic        fifo_ov;
    logic [15:0] fifo_word;
    logic        pop;

    // ----------------------------------------------------------------
    // payload buffer
    // ----------------------------------------------------------------
    utf_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (pl_valid),
        .in_data   (pl_data),
        .in_ready  (pl_ready),
        .out_valid (fifo_ov),
        .out_data  (fifo_word),
        .out_ready (pop)
    );

    // ----------------------------------------------------------------
    // frame start and field snapshot
    // ----------------------------------------------------------------
    assign load       = !tx_valid || tx_ready;
    assign start_meas = cfg.meas_mode && (!cfg.triggered || trig_pend_reg); // (R3)
    assign start_cmd  = !cfg.meas_mode && ack_pend_reg; // (R4)
    // waits for the previous last beat to leave so the new snapshot never skews it
    assign start      = (st_reg == ST_IDLE) && load && (start_meas || start_cmd);
    // acknowledgements carry no user words
    assign sel        = !cfg.meas_mode ? 3'h0 : (cfg.len_sel > LEN_SEL_MAX) ? LEN_SEL_MAX : cfg.len_sel; // (R13)

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_meas_reg <= 1'b0;
            cmd_lat_reg    <= '0;
            trans_lat_reg  <= '0;
            stat_lat_reg   <= '0;
            cnt_lat_reg    <= '0;
            scan_lat_reg   <= '0;
            enc_lat_reg    <= '0;
            last_idx_reg   <= HDR_LAST;
            pkt_reg        <= '0;
        end else if (start) begin
            frame_meas_reg <= cfg.meas_mode;
            cmd_lat_reg    <= cfg.meas_mode ? CMD_EVAL : ack_cmd_reg; // (R8)
            trans_lat_reg  <= cfg.meas_mode ? TRANS_MEAS : ack_cmd_reg; // (R9) (R10)
            stat_lat_reg   <= cfg.status;
            cnt_lat_reg    <= LEN_CODE[sel]; // (R13)
            scan_lat_reg   <= scan_reg;
            enc_lat_reg    <= HAS_ENCODER ? enc_count : ENC_NONE; // (R11)
            last_idx_reg   <= HDR_LAST + {LEN_WORDS[sel], 1'b0}; // (R1)
            pkt_reg        <= pkt_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // header word mux, shared by every telegram kind
    // ----------------------------------------------------------------
    always_comb begin
        case (idx_reg[4:1]) // (R2) (R17)
            W_SOF1, W_SOF2: hdr_word = SOF_WORD; // (R6)
            W_CMD:          hdr_word = cmd_lat_reg;
            W_PKT:          hdr_word = pkt_reg - 16'h0001;
            W_TRANS:        hdr_word = trans_lat_reg;
            W_STAT:         hdr_word = stat_lat_reg;
            W_ENC_H:        hdr_word = enc_lat_reg[31:16];
            W_ENC_L:        hdr_word = enc_lat_reg[15:0];
            W_SCAN:         hdr_word = scan_lat_reg;
            W_TYPE:         hdr_word = TYPE_CODE; // (R16)
            W_COUNT:        hdr_word = cnt_lat_reg;
            default:        hdr_word = FILL_WORD; // (R7)
        endcase
    end

    assign hdr_byte = idx_reg[0] ? hdr_word[15:8] : hdr_word[7:0]; // (R5)
    assign pop      = (st_reg == ST_DATA) && load && fifo_ov && half_reg;

    // ----------------------------------------------------------------
    // transmit sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg   <= ST_IDLE;
            idx_reg  <= '0;
            half_reg <= 1'b0;
            tx_valid <= 1'b0;
            tx_beat  <= '0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (load) begin
                        tx_valid <= 1'b0;
                    end
                    if (start) begin
                        st_reg   <= ST_HDR;
                        idx_reg  <= '0;
                        half_reg <= 1'b0;
                    end
                end
                ST_HDR: begin
                    if (load) begin
                        tx_valid     <= 1'b1;
                        tx_beat.data <= hdr_byte;
                        tx_beat.last <= (idx_reg == last_idx_reg);
                        idx_reg      <= idx_reg + 8'h01;
                        if (idx_reg == last_idx_reg) begin
                            st_reg <= ST_IDLE;
                        end else if (idx_reg == HDR_LAST) begin
                            st_reg <= ST_DATA; // (R17)
                        end
                    end
                end
                ST_DATA: begin
                    // an empty buffer stalls the telegram rather than padding it
                    if (load) begin
                        tx_valid <= fifo_ov;
                        if (fifo_ov) begin
                            tx_beat.data <= half_reg ? fifo_word[15:8] : fifo_word[7:0]; // (R5)
                            tx_beat.last <= (idx_reg == last_idx_reg);
                            idx_reg      <= idx_reg + 8'h01;
                            half_reg     <= !half_reg;
                            if (idx_reg == last_idx_reg) begin
                                st_reg <= ST_IDLE; // (R1)
                            end
                        end
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // trigger, scan and port bookkeeping
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trig_pend_reg <= 1'b0;
        end else if (trigger) begin
            trig_pend_reg <= 1'b1; // (R3)
        end else if (start && cfg.meas_mode) begin
            trig_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scan_reg <= '0;
        end else if (profile_done) begin
            scan_reg <= scan_reg + 16'h0001; // (R12) (R15)
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_port_a <= PORT_A_DFLT; // (R14)
            tx_port_b <= PORT_B_DFLT;
        end else begin
            tx_port_a <= cfg.port_a; // (R14)
            tx_port_b <= cfg.port_b;
        end
    end

    // ----------------------------------------------------------------
    // command receiver
    // ----------------------------------------------------------------
    assign hdr_done = rx_valid && (rx_idx_reg == HDR_LAST) && sof_ok_reg && !cfg.meas_mode; // (R4)

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_idx_reg <= '0;
            sof_ok_reg <= 1'b0;
            rx_cmd_reg <= '0;
        end else if (rx_valid) begin
            rx_idx_reg <= rx_last ? 8'h00 : (rx_idx_reg == RX_IDX_SAT) ? rx_idx_reg : rx_idx_reg + 8'h01;
            if (rx_idx_reg == 8'h00) begin
                sof_ok_reg <= (rx_data == SOF_WORD[7:0]); // (R6)
            end else if (rx_idx_reg <= RX_SOF_LAST) begin
                sof_ok_reg <= sof_ok_reg && (rx_data == SOF_WORD[7:0]); // (R6)
            end
            if (rx_idx_reg == RX_CMD_LO) begin
                rx_cmd_reg[7:0] <= rx_data; // (R5)
            end
            if (rx_idx_reg == RX_CMD_HI) begin
                rx_cmd_reg[15:8] <= rx_data;
            end
        end
    end

    // a newer command overwrites one not yet answered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_pend_reg <= 1'b0;
            ack_cmd_reg  <= '0;
        end else if (hdr_done) begin
            ack_pend_reg <= 1'b1; // (R4)
            ack_cmd_reg  <= rx_cmd_reg; // (R10)
        end else if (start && !cfg.meas_mode) begin
            ack_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic       acc;
    logic [7:0] chk_beat_reg;
    assign acc = tx_valid && tx_ready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chk_beat_reg <= '0;
        end else if (acc) begin
            chk_beat_reg <= tx_beat.last ? 8'h00 : chk_beat_reg + 8'h01;
        end
    end

    chk_sof_bytes: assert property (@(posedge clk) disable iff (!nrst) // (R6)
        acc && chk_beat_reg < 8'h04 |-> tx_beat.data == 8'hFF)
        else $error("start sequence byte is not all ones");
    chk_fill_zero: assert property (@(posedge clk) disable iff (!nrst) // (R7)
        acc && chk_beat_reg inside {8'h04, 8'h05, 8'h08, 8'h09, 8'h0C, 8'h0D, 8'h16, 8'h17} |-> tx_beat.data == 8'h00)
        else $error("fill byte is not zero");
    chk_eval_code: assert property (@(posedge clk) disable iff (!nrst) // (R8)
        acc && frame_meas_reg && chk_beat_reg inside {8'h06, 8'h07} |->
            tx_beat.data == (chk_beat_reg[0] ? CMD_EVAL[15:8] : CMD_EVAL[7:0]))
        else $error("measure telegram command number is wrong");
    chk_meas_trans: assert property (@(posedge clk) disable iff (!nrst) // (R9)
        acc && frame_meas_reg && chk_beat_reg inside {8'h0E, 8'h0F} |-> tx_beat.data == 8'h00)
        else $error("measure telegram transaction number is not zero");
    chk_ack_trans: assert property (@(posedge clk) disable iff (!nrst) // (R10)
        acc && !frame_meas_reg && chk_beat_reg == 8'h0E |-> tx_beat.data == cmd_lat_reg[7:0])
        else $error("acknowledgement does not echo the command number");
    chk_enc_zero: assert property (@(posedge clk) disable iff (!nrst) // (R11)
        acc && !HAS_ENCODER && chk_beat_reg inside {[8'h12:8'h15]} |-> tx_beat.data == 8'h00)
        else $error("encoder field is not zero without an encoder");
    chk_scan_step: assert property (@(posedge clk) disable iff (!nrst) // (R15)
        profile_done |=> scan_reg == $past(scan_reg) + 16'h0001)
        else $error("scan number did not step by one");
    chk_type_code: assert property (@(posedge clk) disable iff (!nrst) // (R16)
        acc && chk_beat_reg == 8'h1A |-> tx_beat.data == TYPE_CODE[7:0])
        else $error("type field low byte is wrong");
    chk_frame_len: assert property (@(posedge clk) disable iff (!nrst) // (R1)
        acc && tx_beat.last |-> chk_beat_reg == last_idx_reg && last_idx_reg >= HDR_LAST)
        else $error("telegram length does not match its word count");
    chk_count_low: assert property (@(posedge clk) disable iff (!nrst) // (R5)
        acc && chk_beat_reg == 8'h1C |-> tx_beat.data == cnt_lat_reg[7:0])
        else $error("word count does not leave low byte first");
    chk_trig_once: assert property (@(posedge clk) disable iff (!nrst) // (R3)
        start && cfg.meas_mode && cfg.triggered |-> trig_pend_reg ##1 (!trig_pend_reg || $past(trigger)))
        else $error("triggered telegram started without a trigger");
    chk_beat_hold: assert property (@(posedge clk) disable iff (!nrst) // (R17)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
        else $error("beat changed while stalled");
endmodule // utf_framer

`default_nettype wire

// >>> rtl/utf_pkg.sv
// package: telegram layout constants and carrier types of the udp telegram framer
package utf_pkg;

    // ----------------------------------------------------------------
    // telegram geometry
    // ----------------------------------------------------------------
    localparam int          HDR_BYTES   = 30;
    localparam int          MAX_WORDS   = 75;
    localparam int          WORD_BITS   = 16;
    localparam int          FIFO_DEPTH  = 4;
    localparam logic [7:0]  HDR_LAST    = 8'(HDR_BYTES - 1);

    // ----------------------------------------------------------------
    // fixed field values
    // ----------------------------------------------------------------
    localparam logic [15:0] SOF_WORD    = 16'hFFFF;
    localparam logic [15:0] FILL_WORD   = 16'h0000;
    localparam logic [15:0] CMD_EVAL    = 16'h5354;
    localparam logic [15:0] TRANS_MEAS  = 16'h0000;
    localparam logic [15:0] TYPE_CODE   = 16'h0010;
    localparam logic [31:0] ENC_NONE    = 32'h0000_0000;
    localparam logic [15:0] PORT_A_DFLT = 16'h2330;
    localparam logic [15:0] PORT_B_DFLT = 16'h1602;

    // ----------------------------------------------------------------
    // user-data word count codes, selected by index
    // ----------------------------------------------------------------
    localparam logic [2:0]  LEN_SEL_MAX = 3'h4;
    localparam logic [15:0] LEN_CODE [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0178};
    localparam logic [6:0]  LEN_WORDS [5] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'(MAX_WORDS)};

    // ----------------------------------------------------------------
    // header word positions and receive byte positions
    // ----------------------------------------------------------------
    localparam logic [3:0]  W_SOF1  = 4'h0;
    localparam logic [3:0]  W_SOF2  = 4'h1;
    localparam logic [3:0]  W_CMD   = 4'h3;
    localparam logic [3:0]  W_PKT   = 4'h5;
    localparam logic [3:0]  W_TRANS = 4'h7;
    localparam logic [3:0]  W_STAT  = 4'h8;
    localparam logic [3:0]  W_ENC_H = 4'h9;
    localparam logic [3:0]  W_ENC_L = 4'hA;
    localparam logic [3:0]  W_SCAN  = 4'hC;
    localparam logic [3:0]  W_TYPE  = 4'hD;
    localparam logic [3:0]  W_COUNT = 4'hE;
    localparam logic [7:0]  RX_SOF_LAST = 8'h03;
    localparam logic [7:0]  RX_CMD_LO   = 8'h06;
    localparam logic [7:0]  RX_CMD_HI   = 8'h07;
    localparam logic [7:0]  RX_IDX_SAT  = 8'hFF;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum {ST_IDLE, ST_HDR, ST_DATA} utf_state_e;

    typedef struct packed {
        logic        meas_mode;
        logic        triggered;
        logic [2:0]  len_sel;
        logic [15:0] status;
        logic [15:0] port_a;
        logic [15:0] port_b;
    } utf_cfg_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } utf_beat_s;

endpackage

// >>> testbench/tb.sv
// testbench: drives the udp telegram framer, queues the expected stream and compares it
`timescale 1ns/1ns
`default_nettype none
module tb;
    import utf_pkg::*;
    logic        clk, nrst, trigger, profile_done, pl_valid, pl_ready, slow;
    logic        rx_valid, rx_last, tx_ready, tx_valid;
    logic [7:0]  rx_data;
    logic [15:0] pl_data, tx_port_a, tx_port_b, pkt, scan, c;
    logic [31:0] enc_count, rng;
    utf_cfg_s    cfg;
    utf_beat_s   tx_beat;
    utf_beat_s   exp_q[$];
    logic [15:0] pl_q[$], pay_q[$];
    int          mismatches, checks_done, tel_seen;

    utf_framer #(.HAS_ENCODER(1'b0)) uut (.clk(clk), .nrst(nrst), .cfg(cfg), .trigger(trigger),
        .profile_done(profile_done), .enc_count(enc_count), .pl_valid(pl_valid), .pl_data(pl_data),
        .pl_ready(pl_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_beat(tx_beat), .tx_port_a(tx_port_a), .tx_port_b(tx_port_b));
    utf_host_model host (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .tx_ready(tx_ready));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic add_words(input int n);
        repeat (n) begin
            rng = xs(rng);
            pl_q.push_back(rng[15:0]);
            pay_q.push_back(rng[15:0]);
        end
    endtask

    // whole telegram as bytes; the header reads the status that stands at frame start
    task automatic push_tel(input logic [15:0] cmd, input logic [15:0] trans, input int sel);
        logic [15:0] w[$];
        w = '{SOF_WORD, SOF_WORD, FILL_WORD, cmd, FILL_WORD, pkt, FILL_WORD, trans, cfg.status,
              ENC_NONE[31:16], ENC_NONE[15:0], FILL_WORD, scan, TYPE_CODE, LEN_CODE[sel]};
        repeat (int'(LEN_WORDS[sel])) w.push_back(pay_q.pop_front());
        foreach (w[i]) begin
            exp_q.push_back('{w[i][7:0], 1'b0});
            exp_q.push_back('{w[i][15:8], i == w.size() - 1});
        end
        pkt++;
    endtask

    task automatic wait_tel(input int k);
        int t;
        t = tel_seen + k;
        for (int i = 0; i < 3000 && tel_seen < t; i++) @(negedge clk);
        check("tel_count", tel_seen, t);
    endtask

    task automatic fire;
        trigger = 1'b1;
        @(negedge clk);
        trigger = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // payload feeder and stream comparator
    // ----------------------------------------------------------------
    always @(posedge clk) if (pl_valid && pl_ready) void'(pl_q.pop_front());
    always @(negedge clk) begin
        pl_valid <= pl_q.size() > 0;
        pl_data  <= (pl_q.size() > 0) ? pl_q[0] : ~pl_data;
    end

    always @(posedge clk) if (nrst && tx_valid && tx_ready) begin
        if (exp_q.size() == 0) check("tx_extra", tx_beat, 32'hFFFF_FFFF);
        else check("tx_beat", tx_beat, exp_q.pop_front());
        if (tx_beat.last) tel_seen++;
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #(4 * 90000);
        mismatches++;
        print_verdict;
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        rng = 32'h3d8d;
        {mismatches, checks_done, tel_seen} = '0;
        {pkt, scan} = '0;
        cfg = '{1'b0, 1'b0, 3'h0, 16'h0000, 16'h1234, 16'h5678};
        {trigger, profile_done, slow} = '0;
        pl_valid <= 1'b0;
        pl_data  <= 16'h0000;
        enc_count = 32'hC3A5_5A3C;
        nrst = 1'b0;
        repeat (20) @(negedge clk);
        check("port_a_rst", tx_port_a, 16'h2330);
        check("port_b_rst", tx_port_b, 16'h1602);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        check("port_a", tx_port_a, 16'h1234);
        check("port_b", tx_port_b, 16'h5678);
        add_words(5);
        repeat (12) @(negedge clk);
        check("pl_ready_full", pl_ready, 1'b0);
        check("pl_backlog", pl_q.size(), 1);
        slow = 1'b1;
        rng = xs(rng);
        cfg.status = rng[15:0];
        push_tel(16'h434E, 16'h434E, 0);
        host.send_cmd(16'h434E);
        wait_tel(1);
        rng = xs(rng);
        c = rng[15:0];
        push_tel(c, c, 0);
        host.send_cmd(c);
        wait_tel(1);
        cfg.meas_mode = 1'b1;
        cfg.triggered = 1'b1;
        // a command in measure mode must not be answered
        host.send_cmd(16'h1111);
        for (int s = 4; s >= 0; s--) begin
            add_words((s == 4) ? 70 : s);
            cfg.len_sel = 3'(s);
            push_tel(CMD_EVAL, TRANS_MEAS, s);
            fire;
            wait_tel(1);
        end
        profile_done = 1'b1;
        repeat (65535) @(negedge clk);
        profile_done = 1'b0;
        scan = 16'hFFFF;
        push_tel(CMD_EVAL, TRANS_MEAS, 0);
        fire;
        wait_tel(1);
        profile_done = 1'b1;
        @(negedge clk);
        profile_done = 1'b0;
        scan = 16'h0000;
        push_tel(CMD_EVAL, TRANS_MEAS, 0);
        fire;
        wait_tel(1);
        slow = 1'b0;
        repeat (3) push_tel(CMD_EVAL, TRANS_MEAS, 0);
        cfg.triggered = 1'b0;
        wait_tel(2);
        repeat (3) @(negedge clk);
        cfg.triggered = 1'b1;
        wait_tel(1);
        repeat (60) @(negedge clk);
        check("exp_left", exp_q.size(), 0);
        print_verdict;
    end
endmodule // tb
`default_nettype wire

// >>> testbench/utf_host_model.sv
// partner model: process control that sends command telegrams and sinks the framer stream
`timescale 1ns/1ns
`default_nettype none
module utf_host_model (
    input  wire logic       clk,
    input  wire logic       slow,
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    output var  logic       rx_last,
    output var  logic       tx_ready
);
    logic [2:0] stall_cnt;

    initial begin
        rx_valid  <= 1'b0;
        rx_data   <= 8'hA5;
        rx_last   <= 1'b0;
        tx_ready  <= 1'b1;
        stall_cnt <= 3'h0;
    end

    // slow mode refuses one beat in four so the framer must hold its byte
    always @(negedge clk) begin
        stall_cnt <= stall_cnt + 3'h1;
        tx_ready  <= !slow || (stall_cnt[1:0] != 2'h0);
    end

    task automatic send_cmd(input logic [15:0] cmd);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 30; i++) begin
            b = (i < 4) ? 8'hFF : (i == 6) ? cmd[7:0] : (i == 7) ? cmd[15:8] : (i == 26) ? 8'h10 : 8'h00;
            @(negedge clk);
            rx_valid <= 1'b1;
            rx_data  <= b;
            rx_last  <= (i == 29);
        end
        @(negedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b; // released line shows the inverse, never a stale copy
        rx_last  <= 1'b0;
    endtask
endmodule // utf_host_model
`default_nettype wire
